//--- gex_map.vh
// Constants of the two-wire port expander core: address, command codes, reset values.
// Assumes a 10 MHz system clock; included by every design file of the block.
`ifndef GEX_MAP_VH
`define GEX_MAP_VH

// ----------------------------------------------------------------------------
// Slave address
// ----------------------------------------------------------------------------
`define GEX_ADDR_FIXED   5'h1c
`define GEX_RW_READ      1'b1

// ----------------------------------------------------------------------------
// Command byte register codes
// ----------------------------------------------------------------------------
`define GEX_REG_INPUT    2'h0
`define GEX_REG_OUTPUT   2'h1
`define GEX_REG_POLARITY 2'h2
`define GEX_REG_DIR      2'h3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define GEX_OUT_RST      8'hff
`define GEX_POL_RST      8'h00
`define GEX_DIR_RST      8'hff
`define GEX_PTR_RST      2'h0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define GEX_CLK_NS       100
`define GEX_SPIKE_NS     50
// Glitch filter depth: spike time in clocks, rounded up, plus one
`define GEX_FILT_LEN     ((`GEX_SPIKE_NS + `GEX_CLK_NS - 1) / `GEX_CLK_NS + 1)
// Clocks after reset during which the interrupt reference tracks the settling pins
`define GEX_SEED_CYC     4'h8

`endif

//--- gex_sync.v
// Two-flop synchroniser followed by a majority-free agreement glitch filter.
// Assumes asynchronous inputs; FILT_LEN must be 2 or more.
`timescale 1ns/1ps
`include "gex_map.vh"

module gex_sync #(
  parameter             WIDTH    = 1,
  parameter             FILT_LEN = 2,
  parameter [WIDTH-1:0] RST_VAL  = {WIDTH{1'b0}}
) (
  input  wire             sys_clk,  // System clock
  input  wire             rst,      // Asynchronous reset, active high
  input  wire [WIDTH-1:0] d_in,     // Asynchronous inputs
  output wire [WIDTH-1:0] q_out     // Synchronised, filtered levels
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg                meta_r;
      reg                sync_r;
      reg [FILT_LEN-1:0] hist_r;
      reg                q_r;

      // ----------------------------------------------------------------------
      // Level changes only after FILT_LEN+1 agreeing samples
      // ----------------------------------------------------------------------
      always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          meta_r <= RST_VAL[i];
          sync_r <= RST_VAL[i];
          hist_r <= {FILT_LEN{RST_VAL[i]}};
          q_r    <= RST_VAL[i];
        end else begin
          meta_r <= d_in[i];
          sync_r <= meta_r;
          hist_r <= {hist_r[FILT_LEN-2:0], sync_r};
          if (&{hist_r, sync_r}) begin
            q_r <= 1'b1;
          end else if (~|{hist_r, sync_r}) begin
            q_r <= 1'b0;
          end
        end
      end

      assign q_out[i] = q_r;
    end
  endgenerate

endmodule // gex_sync

//--- gex_irq.v
// Change-detect interrupt for the input-mode pins of the port.
// Assumes pins already synchronised to sys_clk and clear as a one-cycle pulse.
`timescale 1ns/1ps
`include "gex_map.vh"

module gex_irq #(
  parameter WIDTH = 8
) (
  input  wire             sys_clk,  // System clock
  input  wire             rst,      // Asynchronous reset, active high
  input  wire [WIDTH-1:0] pins,     // Synchronised pin levels
  input  wire [WIDTH-1:0] dir,      // Direction, 1 = input
  input  wire             clear,    // Clearing read acknowledge pulse
  output reg              irq_act   // Interrupt pending, active high
);

  reg [WIDTH-1:0] ref_r;
  reg [3:0]       seed_r;

  // --------------------------------------------------------------------------
  // Reference levels and pending flag
  // --------------------------------------------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ref_r    <= {WIDTH{1'b0}};
      seed_r   <= 4'h0;
      irq_act  <= 1'b0;
    end else begin
      if (seed_r != `GEX_SEED_CYC || clear) begin
        // Changes landing in the clear cycle are absorbed
        ref_r    <= pins;
        irq_act  <= 1'b0;
        // Pin filters restart from zero, so track them until settled
        if (seed_r != `GEX_SEED_CYC) begin
          seed_r <= seed_r + 4'h1;
        end
      end else begin
        // Output-mode pins are masked; returning to ref drops it
        irq_act <= |((pins ^ ref_r) & dir);
      end
    end
  end

endmodule // gex_irq

//--- gex_core.v
// Eight-bit port expander core behind a two-wire serial slave interface.
// Assumes SCL/SDA and port pins are external wires resolved by the surroundings
// from the out/oe pairs; rst is the power-on reset.
//
// Operation
// - Holding ext_reset_n low forces registers and bus state machine to defaults.
// - After ext_reset_n rises, normal pin and bus operation resumes.
// - Power-on reset holds everything in reset, then all initialise to defaults.
// - Input-mode pins have both drivers off, leaving the pin high impedance.
// - Output-mode pins enable one driver: high for latch 1, low for 0.
// - Any edge on an input-mode pin asserts the interrupt.
// - Pins returning to their captured levels deassert the interrupt.
// - Input port read clears the interrupt at the acknowledge clock rising edge.
// - Changes during the clearing acknowledge pulse may be absorbed.
// - After clearing, every further input change raises the interrupt again.
// - Output-mode pins never cause an interrupt.
// - Traffic for other slaves leaves interrupt logic untouched.
// - Switching a pin to input may raise an interrupt on mismatch.
// - Interrupt output is open-drain active low, only pulling low.
// - Start is SDA falling with SCL high; address MSB first, then R/W.
// - Matching address is acknowledged by holding SDA low on ninth clock.
// - SDA changes only with SCL low; changes with SCL high are Start/Stop.
// - Stop is SDA rising with SCL high; device returns to idle.
// - Each byte is eight bits plus acknowledge; transmitter releases SDA.
// - Device acks received bytes; on master nack it releases SDA.
// - Address is 11100 plus both straps; last bit 1 reads, 0 writes.
// - Command low bits pick input/output/polarity/direction; reset values set.
// - Selected register stays selected until a new command byte.
// - Direction 1 makes pin input, 0 makes it driven output.
`timescale 1ns/1ps
`include "gex_map.vh"

module gex_core #(
  parameter WIDTH    = 8,
  parameter FILT_LEN = `GEX_FILT_LEN
) (
  input  wire             sys_clk,           // System clock, 10 MHz
  input  wire             rst,               // Power-on reset, active high, async
  input  wire             ext_reset_n,       // External reset pin, active low
  input  wire             scl_in,            // Bus clock line level
  input  wire             sda_in,            // Bus data line level
  output wire             sda_out,           // Bus data drive value, always low
  output wire             sda_oe,            // Bus data pull-down enable
  input  wire             addr_strap_lo,     // Address strap, bit 0
  input  wire             addr_strap_hi,     // Address strap, bit 1
  input  wire [WIDTH-1:0] port_pins_in,      // Port pin levels
  output wire [WIDTH-1:0] port_pins_out,     // Port pin drive values
  output wire [WIDTH-1:0] port_pins_oe,      // Port pin drive enables
  output wire [WIDTH-1:0] high_side_driver,  // High-side driver on
  output wire [WIDTH-1:0] low_side_driver,   // Low-side driver on
  output wire             irq_n_out,         // Interrupt drive value, always low
  output wire             irq_n_oe           // Interrupt pull-down enable
);

  // --------------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ADDR = 4'h1;
  localparam [3:0] ST_AACK = 4'h2;
  localparam [3:0] ST_CMD  = 4'h3;
  localparam [3:0] ST_CACK = 4'h4;
  localparam [3:0] ST_WDAT = 4'h5;
  localparam [3:0] ST_WACK = 4'h6;
  localparam [3:0] ST_RDAT = 4'h7;
  localparam [3:0] ST_RACK = 4'h8;
  localparam [3:0] ST_IGN  = 4'h9;

  // --------------------------------------------------------------------------
  // Reset combine and synchronise
  // --------------------------------------------------------------------------
  wire raw_rst = rst | ~ext_reset_n;
  reg  rst_meta_r;
  reg  rst_sync_r;
  wire core_rst = rst_sync_r;

  // Asserts at once, releases two clocks after both resets go away
  always @(posedge sys_clk or posedge raw_rst) begin
    if (raw_rst) begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= 1'b1;
    end else begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= rst_meta_r;
    end
  end

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  wire [1:0]       bus_s;
  wire [1:0]       strap_s;
  wire [WIDTH-1:0] pins_s;
  wire             scl_s = bus_s[1];
  wire             sda_s = bus_s[0];

  gex_sync #(
    .WIDTH    (2),
    .FILT_LEN (FILT_LEN),
    .RST_VAL  (2'h3)
  ) u_bus_sync (
    .sys_clk (sys_clk),
    .rst     (core_rst),
    .d_in    ({scl_in, sda_in}),
    .q_out   (bus_s)
  );

  gex_sync #(
    .WIDTH    (2),
    .FILT_LEN (FILT_LEN),
    .RST_VAL  (2'h0)
  ) u_strap_sync (
    .sys_clk (sys_clk),
    .rst     (core_rst),
    .d_in    ({addr_strap_hi, addr_strap_lo}),
    .q_out   (strap_s)
  );

  gex_sync #(
    .WIDTH    (WIDTH),
    .FILT_LEN (FILT_LEN),
    .RST_VAL  ({WIDTH{1'b0}})
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .rst     (core_rst),
    .d_in    (port_pins_in),
    .q_out   (pins_s)
  );

  // --------------------------------------------------------------------------
  // Bus condition detection
  // --------------------------------------------------------------------------
  reg  scl_d_r;
  reg  sda_d_r;

  always @(posedge sys_clk or posedge core_rst) begin
    if (core_rst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  // SDA edges while SCL stays high are conditions, never data
  wire start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // --------------------------------------------------------------------------
  // Registers and read data selection
  // --------------------------------------------------------------------------
  reg  [3:0]       state_r;
  reg  [3:0]       bit_cnt_r;
  reg  [7:0]       shift_r;
  reg  [1:0]       ptr_r;
  reg              rw_r;
  reg              mack_r;
  reg              sda_oe_r;
  reg              clr_r;
  reg  [WIDTH-1:0] out_r;
  reg  [WIDTH-1:0] pol_r;
  reg  [WIDTH-1:0] dir_r;

  wire [WIDTH-1:0] in_reg = pins_s ^ pol_r;
  wire [6:0]       my_addr = {`GEX_ADDR_FIXED, strap_s[1], strap_s[0]};

  function [7:0] rd_sel;
    input [1:0]       sel;
    input [WIDTH-1:0] inp;
    input [WIDTH-1:0] outp;
    input [WIDTH-1:0] pol;
    input [WIDTH-1:0] dir;
    begin
      case (sel)
        `GEX_REG_INPUT:    rd_sel = inp;
        `GEX_REG_OUTPUT:   rd_sel = outp;
        `GEX_REG_POLARITY: rd_sel = pol;
        default:           rd_sel = dir;
      endcase
    end
  endfunction

  wire [7:0] rd_byte = rd_sel(ptr_r, in_reg, out_r, pol_r, dir_r);

  // --------------------------------------------------------------------------
  // Serial slave state machine
  // --------------------------------------------------------------------------
  always @(posedge sys_clk or posedge core_rst) begin
    if (core_rst) begin
      state_r   <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r   <= 8'h00;
      ptr_r     <= `GEX_PTR_RST;
      rw_r      <= 1'b0;
      mack_r    <= 1'b0;
      sda_oe_r  <= 1'b0;
      clr_r     <= 1'b0;
      out_r     <= `GEX_OUT_RST;
      pol_r     <= `GEX_POL_RST;
      dir_r     <= `GEX_DIR_RST;
    end else begin
      clr_r <= 1'b0;
      if (stop_c) begin
        state_r  <= ST_IDLE;
        sda_oe_r <= 1'b0;
      end else if (start_c) begin
        state_r   <= ST_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe_r  <= 1'b0;
      end else begin
        case (state_r)
          ST_ADDR, ST_CMD, ST_WDAT: begin
            if (scl_rise) begin
              // MSB arrives first
              shift_r   <= {shift_r[6:0], sda_s};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == 4'h8) begin
              bit_cnt_r <= 4'h0;
              if (state_r == ST_ADDR) begin
                if (shift_r[7:1] == my_addr) begin
                  rw_r     <= shift_r[0];
                  sda_oe_r <= 1'b1;
                  state_r  <= ST_AACK;
                end else begin
                  state_r <= ST_IGN;
                end
              end else if (state_r == ST_CMD) begin
                ptr_r    <= shift_r[1:0];
                sda_oe_r <= 1'b1;
                state_r  <= ST_CACK;
              end else begin
                case (ptr_r)
                  `GEX_REG_OUTPUT:   out_r <= shift_r;
                  `GEX_REG_POLARITY: pol_r <= shift_r;
                  `GEX_REG_DIR:      dir_r <= shift_r;
                  default:           ;
                endcase
                sda_oe_r <= 1'b1;
                state_r  <= ST_WACK;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              bit_cnt_r <= 4'h0;
              if (rw_r == `GEX_RW_READ) begin
                shift_r  <= rd_byte;
                sda_oe_r <= ~rd_byte[7];
                state_r  <= ST_RDAT;
              end else begin
                sda_oe_r <= 1'b0;
                state_r  <= ST_CMD;
              end
            end
          end
          ST_CACK, ST_WACK: begin
            if (scl_fall) begin
              sda_oe_r <= 1'b0;
              state_r  <= ST_WDAT;
            end
          end
          ST_RDAT: begin
            if (scl_rise) begin
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt_r == 4'h8) begin
                // Release so the master can answer
                sda_oe_r <= 1'b0;
                state_r  <= ST_RACK;
              end else begin
                sda_oe_r <= ~shift_r[6];
                shift_r  <= {shift_r[6:0], 1'b0};
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              mack_r <= ~sda_s;
              if (ptr_r == `GEX_REG_INPUT) begin
                clr_r <= 1'b1;
              end
            end else if (scl_fall) begin
              bit_cnt_r <= 4'h0;
              if (mack_r) begin
                shift_r  <= rd_byte;
                sda_oe_r <= ~rd_byte[7];
                state_r  <= ST_RDAT;
              end else begin
                state_r <= ST_IGN;
              end
            end
          end
          ST_IGN: begin
            sda_oe_r <= 1'b0;
          end
          default: begin
            state_r  <= ST_IDLE;
            sda_oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt
  // --------------------------------------------------------------------------
  wire irq_act;

  gex_irq #(
    .WIDTH (WIDTH)
  ) u_irq (
    .sys_clk (sys_clk),
    .rst     (core_rst),
    .pins    (pins_s),
    .dir     (dir_r),
    .clear   (clr_r),
    .irq_act (irq_act)
  );

  // --------------------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------------------
  reg [WIDTH-1:0] pin_out_r;
  reg [WIDTH-1:0] pin_oe_r;
  reg [WIDTH-1:0] hi_drv_r;
  reg [WIDTH-1:0] lo_drv_r;
  reg             od_low_r;

  always @(posedge sys_clk or posedge core_rst) begin
    if (core_rst) begin
      pin_out_r <= `GEX_OUT_RST;
      pin_oe_r  <= {WIDTH{1'b0}};
      hi_drv_r  <= {WIDTH{1'b0}};
      lo_drv_r  <= {WIDTH{1'b0}};
      od_low_r  <= 1'b0;
    end else begin
      pin_out_r <= out_r;
      pin_oe_r  <= ~dir_r;
      hi_drv_r  <= ~dir_r & out_r;
      lo_drv_r  <= ~dir_r & ~out_r;
      od_low_r  <= 1'b0;
    end
  end

  assign sda_out          = od_low_r;
  assign sda_oe           = sda_oe_r;
  assign port_pins_out    = pin_out_r;
  assign port_pins_oe     = pin_oe_r;
  assign high_side_driver = hi_drv_r;
  assign low_side_driver  = lo_drv_r;
  assign irq_n_out        = od_low_r;
  assign irq_n_oe         = irq_act;

endmodule // gex_core

//--- gex_core_props.sv
// Checker of the port expander core, bound to gex_core.
// Assumes sys_clk at 10 MHz and resolved bus line levels.
`timescale 1ns/1ps
module gex_core_props #(
  parameter WIDTH = 8
) (
  input wire             sys_clk,          // Clock
  input wire             rst,              // Power-on reset
  input wire             ext_reset_n,      // External reset
  input wire             scl_in,           // Bus clock
  input wire             sda_in,           // Bus data
  input wire             sda_out,          // Data value
  input wire             sda_oe,           // Data pull
  input wire             addr_strap_lo,    // Strap 0
  input wire             addr_strap_hi,    // Strap 1
  input wire [WIDTH-1:0] port_pins_in,     // Pin levels
  input wire [WIDTH-1:0] port_pins_out,    // Pin values
  input wire [WIDTH-1:0] port_pins_oe,     // Pin enables
  input wire [WIDTH-1:0] high_side_driver, // High side
  input wire [WIDTH-1:0] low_side_driver,  // Low side
  input wire             irq_n_out,        // Irq value
  input wire             irq_n_oe          // Irq pull
);
  // ----------------------------------------------------------------
  // Cycles since the last bus clock edge or pin change
  // ----------------------------------------------------------------
  logic [7:0]       fall_r, rise_r, chg_r;
  logic             scl_r;
  logic [WIDTH-1:0] pin_r, oe_r;

  function automatic logic [7:0] sat(input logic [7:0] c);
    return (c == 8'hff) ? c : c + 8'h01;
  endfunction

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scl_r  <= 1'b1;
      pin_r  <= '0;
      oe_r   <= '0;
      fall_r <= 8'hff;
      rise_r <= 8'hff;
      chg_r  <= 8'hff;
    end else begin
      scl_r  <= scl_in;
      pin_r  <= port_pins_in;
      oe_r   <= port_pins_oe;
      fall_r <= (scl_r && !scl_in) ? 8'h00 : sat(fall_r);
      rise_r <= (!scl_r && scl_in) ? 8'h00 : sat(rise_r);
      chg_r  <= (pin_r != port_pins_in || oe_r != port_pins_oe) ? 8'h00 : sat(chg_r);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_scl_high;
    scl_in [*3];
  endsequence
  sequence s_ext_low;
    !ext_reset_n [*2];
  endsequence

  chk_od_low_only: assert property (
    !irq_n_out && !sda_out) else $error("open-drain value not low");
  chk_drv_onehot: assert property (
    (high_side_driver & low_side_driver) == '0
    && (high_side_driver | low_side_driver) == port_pins_oe) else $error("driver pair wrong");
  chk_drv_latch: assert property (
    high_side_driver == (port_pins_oe & port_pins_out)) else $error("high side not latch");
  chk_ext_reset: assert property (
    s_ext_low |-> port_pins_oe == '0 && port_pins_out == '1 && !irq_n_oe && !sda_oe)
    else $error("reset defaults missing");
  chk_sda_hold: assert property (
    s_scl_high |-> $stable(sda_oe)) else $error("data moved with clock high");
  chk_sda_after_fall: assert property (
    !$stable(sda_oe) |-> fall_r inside {[3:10]}) else $error("data drive off time");
  chk_irq_cause: assert property (
    $rose(irq_n_oe) |-> chg_r < 8'd12) else $error("interrupt without change");
  chk_irq_release: assert property (
    $fell(irq_n_oe) |-> chg_r < 8'd12 || rise_r < 8'd10 || !ext_reset_n)
    else $error("interrupt dropped without cause");
  chk_pin_update: assert property (
    !$stable(port_pins_oe) || !$stable(port_pins_out) |-> fall_r inside {[3:12]} || !ext_reset_n)
    else $error("pin drive moved off a byte end");
endmodule // gex_core_props

//--- gex_i2c_master.sv
// Behavioural two-wire bus master for the expander bench.
// Assumes open-drain lines resolved with pull-ups in the bench.
`timescale 1ns/1ps
module gex_i2c_master #(
  parameter Q_NS = 600
) (
  input  wire  sda_line, // Resolved data line
  output logic scl_drv,  // Clock line level
  output logic sda_low   // Pulls data low
);
  logic [7:0] rx_byte;
  event       rx_done;

  initial begin
    scl_drv = 1'b1;
    sda_low = 1'b0;
  end

  // Also serves as repeated start from a low clock
  task automatic start();
    sda_low = 1'b0;
    #Q_NS scl_drv = 1'b1;
    #Q_NS sda_low = 1'b1;
    #Q_NS scl_drv = 1'b0;
    #Q_NS;
  endtask

  task automatic stop();
    sda_low = 1'b1;
    #Q_NS scl_drv = 1'b1;
    #Q_NS sda_low = 1'b0;
    #Q_NS;
  endtask

  task automatic bit_io(input logic b, output logic s);
    sda_low = !b;
    #Q_NS scl_drv = 1'b1;
    #Q_NS s = sda_line;
    #Q_NS scl_drv = 1'b0;
    #Q_NS;
  endtask

  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack);
  endtask

  task automatic rd(input logic nack);
    logic a;
    xfer(8'hff, nack, rx_byte, a);
    -> rx_done;
  endtask
endmodule // gex_i2c_master

//--- gex_core_tb.sv
// Self-checking bench of the port expander core.
// Assumes gex_core, gex_i2c_master and gex_core_props are compiled.
`timescale 1ns/1ps
`include "gex_map.vh"
module gex_core_tb;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       ext_reset_n = 1'b1;
  logic [1:0] strap = 2'b00;
  logic [7:0] ext_pins = 8'h00;
  logic [7:0] dout, old;
  logic [6:0] addr;
  logic [7:0] exp_q[$];
  integer     fails = 0, checks_done = 0, seed = 83, rnd;
  wire        sda_in, scl_in, sda_out, sda_oe, irq_n_out, irq_n_oe, sda_low;
  wire  [7:0] pins_in, pins_out, pins_oe, hs_drv, ls_drv;
  wire        irq_line = !(irq_n_oe && !irq_n_out);

  always #50 sys_clk = ~sys_clk;
  assign sda_in  = !(sda_low || (sda_oe && !sda_out));
  assign pins_in = (pins_oe & pins_out) | (~pins_oe & ext_pins);

  gex_core i_gex_core (.sys_clk(sys_clk), .rst(rst), .ext_reset_n(ext_reset_n),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strap_lo(strap[0]), .addr_strap_hi(strap[1]), .port_pins_in(pins_in),
    .port_pins_out(pins_out), .port_pins_oe(pins_oe), .high_side_driver(hs_drv),
    .low_side_driver(ls_drv), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
  gex_i2c_master i_gex_i2c_master (.sda_line(sda_in), .scl_drv(scl_in), .sda_low(sda_low));

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(i_gex_i2c_master.rx_done) check(i_gex_i2c_master.rx_byte, exp_q.pop_front());

  task automatic tick(input integer n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic irq_is(input logic e);
    check({7'h00, irq_line}, {7'h00, e});
  endtask

  task automatic wbyte(input logic [7:0] b, input logic exp_ack);
    logic [7:0] r;
    logic       a;
    i_gex_i2c_master.xfer(b, 1'b1, r, a);
    check({7'h00, a}, {7'h00, exp_ack});
  endtask

  task automatic cmd_wr(input logic [1:0] cmd);
    i_gex_i2c_master.start();
    wbyte({addr, 1'b0}, 1'b0);
    wbyte({6'h00, cmd}, 1'b0);
  endtask

  task automatic reg_wr(input logic [1:0] cmd, input logic [7:0] d);
    cmd_wr(cmd);
    wbyte(d, 1'b0);
    i_gex_i2c_master.stop();
  endtask

  task automatic reg_rd(input logic [1:0] cmd, input logic [7:0] e);
    cmd_wr(cmd);
    i_gex_i2c_master.start();
    wbyte({addr, 1'b1}, 1'b0);
    exp_q.push_back(e);
    exp_q.push_back(e);
    i_gex_i2c_master.rd(1'b0);
    i_gex_i2c_master.rd(1'b1);
    i_gex_i2c_master.stop();
  endtask

  initial begin
    #3_000_000;
    fails++;
    $display("watchdog expired");
    end_of_test();
  end

  initial begin
    rnd = $random(seed);
    strap = rnd[1:0];
    addr = {`GEX_ADDR_FIXED, strap};
    tick(20);
    rst = 1'b0;
    tick(20);
    check(pins_oe, 8'h00);
    check(pins_out, `GEX_OUT_RST);
    irq_is(1'b1);
    reg_rd(`GEX_REG_DIR, `GEX_DIR_RST);
    reg_rd(`GEX_REG_POLARITY, `GEX_POL_RST);
    reg_rd(`GEX_REG_OUTPUT, `GEX_OUT_RST);
    $display("test defaults done");
    rnd = $random(seed);
    dout = rnd[7:0];
    reg_wr(`GEX_REG_OUTPUT, dout);
    reg_wr(`GEX_REG_DIR, 8'hf0);
    dout = ~dout;
    reg_wr(`GEX_REG_OUTPUT, dout);
    tick(2);
    check(pins_oe, 8'h0f);
    check(hs_drv, dout & 8'h0f);
    check(ls_drv, ~dout & 8'h0f);
    irq_is(1'b1);
    reg_rd(`GEX_REG_OUTPUT, dout);
    $display("test outputs done");
    reg_wr(`GEX_REG_POLARITY, 8'ha5);
    old = ext_pins;
    rnd = $random(seed);
    ext_pins = old ^ (rnd[7:0] | 8'h80);
    tick(10);
    irq_is(1'b0);
    ext_pins = old;
    tick(10);
    irq_is(1'b1);
    ext_pins = old ^ 8'h40;
    tick(10);
    cmd_wr(`GEX_REG_INPUT);
    i_gex_i2c_master.start();
    wbyte({addr ^ 7'h01, 1'b1}, 1'b1);
    i_gex_i2c_master.stop();
    irq_is(1'b0);
    reg_rd(`GEX_REG_INPUT, ((dout & 8'h0f) | (ext_pins & 8'hf0)) ^ 8'ha5);
    irq_is(1'b1);
    cmd_wr(`GEX_REG_OUTPUT);
    i_gex_i2c_master.stop();
    ext_pins = ext_pins ^ 8'h20;
    tick(10);
    irq_is(1'b0);
    $display("test interrupt done");
    ext_reset_n = 1'b0;
    tick(3);
    check(pins_oe, 8'h00);
    check(pins_out, `GEX_OUT_RST);
    irq_is(1'b1);
    ext_reset_n = 1'b1;
    tick(20);
    irq_is(1'b1);
    reg_rd(`GEX_REG_POLARITY, `GEX_POL_RST);
    reg_wr(`GEX_REG_DIR, 8'h00);
    tick(2);
    check(hs_drv, `GEX_OUT_RST);
    $display("test external reset done");
    end_of_test();
  end
endmodule // gex_core_tb

bind gex_core gex_core_props #(.WIDTH(WIDTH)) i_gex_core_props (.sys_clk(sys_clk),
  .rst(rst), .ext_reset_n(ext_reset_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_lo(addr_strap_lo),
  .addr_strap_hi(addr_strap_hi), .port_pins_in(port_pins_in),
  .port_pins_out(port_pins_out), .port_pins_oe(port_pins_oe),
  .high_side_driver(high_side_driver), .low_side_driver(low_side_driver),
  .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
